/* sa_addr_calc.sv */
// Start address calculator for one backplane slot.
// Assumes slot number and kind are stable inputs from the slot scanner.
`timescale 1ns/1ps
`default_nettype none
module sa_addr_calc (
  input  wire logic [5:0]  slot,
  input  wire logic [1:0]  kind,
  input  wire logic        cfg_valid,
  input  wire logic [15:0] cfg_addr,
  output logic [15:0]      start_addr,
  output logic             addr_valid
);
  logic [15:0] rel;

  // Configured addresses override the formula; without configuration low slots stay unaddressed.
  always_comb begin
    rel        = 16'(slot) - 16'(sa_pkg::FIRST_AUTO_SLOT);
    start_addr = 16'h0000;
    addr_valid = 1'b0;
    if (cfg_valid && kind != sa_pkg::KIND_EMPTY) begin
      start_addr = cfg_addr;
      addr_valid = 1'b1;
    end else if (slot >= 6'(sa_pkg::FIRST_AUTO_SLOT)) begin
      if (kind == sa_pkg::KIND_DIGITAL) begin
        start_addr = sa_pkg::DIG_BASE + 16'(rel * 16'(sa_pkg::DIG_BYTES));
        addr_valid = 1'b1;
      end else if (kind == sa_pkg::KIND_OTHER) begin
        start_addr = sa_pkg::ANA_BASE + 16'(rel * 16'(sa_pkg::ANA_BYTES));
        addr_valid = 1'b1;
      end
    end
  end
endmodule : sa_addr_calc
`default_nettype wire

/* sa_backplane.sv */
// Backplane model: module kind per slot and read data per module address.
// Assumes the scan slot and module address come from the sequencer directly.
`timescale 1ns/1ps
`default_nettype none
module sa_backplane (
  input  wire logic        dense,
  input  wire logic [5:0]  scan_slot,
  input  wire logic [15:0] mod_addr,
  output logic      [1:0]  scan_kind,
  output logic      [15:0] scan_cfg_addr,
  output logic      [7:0]  mod_rdata
);
  // Slot 3 holds the line interface; dense mode overfills the rack.
  always_comb begin
    case (scan_slot)
      6'h02, 6'h04, 6'h09: scan_kind = sa_pkg::KIND_DIGITAL;
      6'h03, 6'h05: scan_kind = sa_pkg::KIND_OTHER;
      default: scan_kind = dense ? sa_pkg::KIND_DIGITAL : sa_pkg::KIND_EMPTY;
    endcase
  end
  // Configured addresses follow the slot so each is unique; read data follows the module address.
  assign scan_cfg_addr = {10'h028, scan_slot};
  assign mod_rdata = ~mod_addr[7:0] ^ mod_addr[15:8];
endmodule : sa_backplane
`default_nettype wire

/* sa_pkg.sv */
// Constants for the start-up sequencer and slot address allocator.
// Assumes a single 10 MHz clock; timing counts derive from it here.
// Function
// - At power-up enter the operating state the mode lever selects.
// - Factory-reset with no program: stop-to-run gives run without program.
// - Valid retained configuration: run with the retained program.
// - Battery recharges from internal supply; memory retained up to 30 days.
// - Lost retained memory forces an overall reset at power-up.
// - After that reset, load program and data from a present memory card.
// - Without card, load stored protected blocks if any exist.
// - After empty-battery reset, run only if lever says run and handler exists.
// - Log the automatic overall reset in the diagnostic event buffer.
// - Empty battery at power-up raises the battery fault flag.
// - Clear battery fault only after 30 s powered with full battery.
// - Shorter power-on intervals keep the flag and repeat the overall reset.
// - Digital modules get addresses from zero, ascending with slot.
// - Without configuration analog modules sit at even addresses from 256.
// - Addresses up to 127 are mirrored in input and output images.
// - Images refresh automatically at each program cycle end.
// - At most 31 modules total and 8 per row.
// - Modules reachable by direct byte access or through the images.
// - Automatic addressing without configuration; configured addresses win.
// - Digital modules take 4 bytes, analog, function, communication 16.
// - Digital start address is 4 times slot minus 4.
// - Other start address is 16 times slot minus 4, plus 256.
package sa_pkg;
  localparam int unsigned CLK_HZ          = 10000000;
  localparam int unsigned BAT_CLEAR_SEC   = 30;
  localparam int unsigned BAT_CLEAR_CYC   = BAT_CLEAR_SEC * CLK_HZ;
  localparam int unsigned RETAIN_DAYS     = 30;
  localparam int unsigned MAX_MODULES     = 31;
  localparam int unsigned MAX_PER_ROW     = 8;
  localparam int unsigned FIRST_AUTO_SLOT = 4;
  localparam int unsigned DIG_BYTES       = 4;
  localparam int unsigned ANA_BYTES       = 16;
  localparam logic [15:0] ANA_BASE        = 16'h0100;
  localparam logic [15:0] DIG_BASE        = 16'h0000;
  localparam logic [7:0]  IMAGE_LAST      = 8'h7f;
  localparam int unsigned IMAGE_BYTES     = 128;
  localparam int unsigned SLOT_W          = 6;
  localparam int unsigned ADDR_W          = 16;
  // Module kind codes reported by a slot.
  localparam logic [1:0]  KIND_EMPTY      = 2'h0;
  localparam logic [1:0]  KIND_DIGITAL    = 2'h1;
  localparam logic [1:0]  KIND_OTHER      = 2'h2;
  // Diagnostic event code for an automatic overall reset.
  localparam logic [7:0]  EVT_AUTO_RESET  = 8'h01;
  localparam logic [7:0]  EVT_NONE        = 8'h00;

  typedef enum logic [8:0] {
    SA_CHECK  = 9'h001,
    SA_WIPE   = 9'h002,
    SA_LOAD   = 9'h004,
    SA_DECIDE = 9'h008,
    SA_STOP   = 9'h010,
    SA_RUN    = 9'h020,
    SA_WRITE  = 9'h040,
    SA_READ   = 9'h080,
    SA_IDLE   = 9'h100
  } sa_state_t;

  typedef enum logic [1:0] {
    SA_SRC_NONE = 2'h0,
    SA_SRC_CARD = 2'h1,
    SA_SRC_PROT = 2'h2
  } sa_src_t;
endpackage : sa_pkg

/* sa_props.sv */
// Concurrent checks on the ports of the start-up sequencer.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sa_props #(
  parameter int unsigned BAT_CLEAR_CYCLES = 50
) (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       battery_full,
  input wire logic       hw_config_valid,
  input wire logic       slot_count_error,
  input wire logic       run_mode,
  input wire logic       program_exec,
  input wire logic       overall_reset,
  input wire logic       battery_fault_flag,
  input wire logic       battery_charge_en,
  input wire logic       diag_event_valid,
  input wire logic [7:0] diag_event_code,
  input wire logic [5:0] scan_slot,
  input wire logic       slot_addr_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [31:0] up_cnt_r;
  // Powered cycles since reset; it saturates so a long run never wraps back.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) up_cnt_r <= 32'h0;
    else if (up_cnt_r != 32'hffffffff) up_cnt_r <= up_cnt_r + 32'h1;
  end
  a_charge_always_on: assert property (battery_charge_en == 1'b1)
    else $error("charge enable low");
  a_reset_logs_event: assert property (overall_reset |-> diag_event_valid)
    else $error("overall reset not logged");
  a_event_code_fixed: assert property (diag_event_valid |-> diag_event_code == sa_pkg::EVT_AUTO_RESET)
    else $error("wrong event code");
  a_reset_sets_flag: assert property (overall_reset |-> ##[0:1] battery_fault_flag)
    else $error("flag not raised");
  a_reset_one_pulse: assert property (overall_reset |=> !overall_reset)
    else $error("overall reset too long");
  a_exec_needs_run: assert property (program_exec |-> run_mode)
    else $error("program runs outside run");
  a_flag_clear_time: assert property ($fell(battery_fault_flag) |-> up_cnt_r >= BAT_CLEAR_CYCLES)
    else $error("flag cleared too early");
  a_flag_clear_full: assert property ($fell(battery_fault_flag) |-> $past(battery_full, 3))
    else $error("flag cleared without full battery");
  a_count_err_sticky: assert property (slot_count_error |=> slot_count_error)
    else $error("count error dropped");
  a_low_slot_unaddr: assert property (slot_addr_valid && !hw_config_valid |-> $past(scan_slot) >= 6'h04)
    else $error("low slot addressed");
  c_auto_reset: cover property (overall_reset);
  c_run_program: cover property (run_mode && program_exec);
  c_flag_cleared: cover property ($fell(battery_fault_flag));
endmodule : sa_props
bind sa_startup sa_props #(.BAT_CLEAR_CYCLES(BAT_CLEAR_CYCLES)) sa_props_inst (.ref_clk, .rst, .battery_full,
  .slot_count_error, .run_mode, .program_exec, .overall_reset, .battery_fault_flag, .battery_charge_en,
  .diag_event_valid, .diag_event_code, .scan_slot, .slot_addr_valid, .hw_config_valid);
`default_nettype wire

/* sa_startup.sv */
// Start-up sequencer, slot address allocator and process image handler.
// Assumes pins for lever, battery, card and config valid are asynchronous and are synchronised here; slot kind and configured address are used directly.
`timescale 1ns/1ps
`default_nettype none
module sa_startup #(
  parameter int unsigned BAT_CLEAR_CYCLES = sa_pkg::BAT_CLEAR_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        lever_run,
  input  wire logic        retained_valid,
  input  wire logic        program_present,
  input  wire logic        battery_full,
  input  wire logic        card_present,
  input  wire logic        protected_present,
  input  wire logic        fault_handler_present,
  input  wire logic        hw_config_valid,
  input  wire logic        load_done,
  input  wire logic        cycle_end,
  input  wire logic [1:0]  scan_kind,
  input  wire logic [15:0] scan_cfg_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic        bus_via_image,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic [7:0]  mod_rdata,
  output logic [5:0]       scan_slot,
  output logic [15:0]      slot_addr,
  output logic             slot_addr_valid,
  output logic             slot_count_error,
  output logic             run_mode,
  output logic             program_exec,
  output logic             overall_reset,
  output logic [1:0]       load_source,
  output logic             battery_fault_flag,
  output logic             battery_charge_en,
  output logic             diag_event_valid,
  output logic [7:0]       diag_event_code,
  output logic             mod_wr,
  output logic             mod_rd,
  output logic [15:0]      mod_addr,
  output logic [7:0]       mod_wdata,
  output logic [7:0]       bus_rdata
);
  typedef struct packed {
    logic [9:0]         sync1;
    logic [9:0]         sync2;
    sa_pkg::sa_state_t  st;
    logic [31:0]        on_cnt;
    logic               bat_flag;
    logic               run;
    logic               exec;
    logic               wipe;
    logic [1:0]         src;
    logic               evt;
    logic [7:0]         evt_code;
    logic [5:0]         slot;
    logic [15:0]        saddr;
    logic               svalid;
    logic [5:0]         nmod;
    logic [3:0]         nrow;
    logic               cnt_err;
    logic [6:0]         img_idx;
    logic               mwr;
    logic               mrd;
    logic [15:0]        maddr;
    logic [7:0]         mwdata;
    logic [7:0]         rdata;
    logic               lever_q;
  } sa_regs_t;

  sa_regs_t    st_r;
  sa_regs_t    st_nxt;
  logic [7:0]  in_image  [0:sa_pkg::IMAGE_BYTES-1];
  logic [7:0]  out_image [0:sa_pkg::IMAGE_BYTES-1];
  logic [15:0] calc_addr;
  logic        calc_valid;
  logic        s_lever;
  logic        s_retain;
  logic        s_prog;
  logic        s_batfull;
  logic        s_card;
  logic        s_prot;
  logic        s_handler;
  logic        s_cfg;
  logic        s_load_done;
  logic        s_cycle_end;
  logic        img_hit;

  assign s_lever     = st_r.sync2[0];
  assign s_retain    = st_r.sync2[1];
  assign s_prog      = st_r.sync2[2];
  assign s_batfull   = st_r.sync2[3];
  assign s_card      = st_r.sync2[4];
  assign s_prot      = st_r.sync2[5];
  assign s_handler   = st_r.sync2[6];
  assign s_cfg       = st_r.sync2[7];
  assign s_load_done = st_r.sync2[8];
  assign s_cycle_end = st_r.sync2[9];
  assign img_hit     = bus_addr <= 16'(sa_pkg::IMAGE_LAST);

  // Per-slot address arithmetic lives in its own small module.
  sa_addr_calc u_calc (
    .slot       (st_r.slot),
    .kind       (scan_kind),
    .cfg_valid  (s_cfg),
    .cfg_addr   (scan_cfg_addr),
    .start_addr (calc_addr),
    .addr_valid (calc_valid)
  );

  // Next-state logic for the whole state register.
  always_comb begin
    st_nxt        = st_r;
    st_nxt.sync1  = {cycle_end, load_done, hw_config_valid, fault_handler_present,
                     protected_present, card_present, battery_full, program_present,
                     retained_valid, lever_run};
    st_nxt.sync2  = st_r.sync1;
    st_nxt.evt    = 1'b0;
    st_nxt.mwr    = 1'b0;
    st_nxt.mrd    = 1'b0;
    st_nxt.svalid = 1'b0; // A stale valid after the scan would mislabel the wrapped slot number.
    st_nxt.lever_q = s_lever;
    // Powered-time counter; saturates so the flag logic never wraps.
    if (st_r.on_cnt < BAT_CLEAR_CYCLES) begin
      st_nxt.on_cnt = st_r.on_cnt + 32'h1;
    end
    // The fault clears only after a long enough powered interval on a full battery.
    if (st_r.bat_flag && s_batfull && st_r.on_cnt >= BAT_CLEAR_CYCLES) begin
      st_nxt.bat_flag = 1'b0;
    end
    case (st_r.st)
      sa_pkg::SA_CHECK: begin
        // Wait one pass so the synchronisers hold real pin values.
        if (st_r.on_cnt >= 32'h3) begin
          if (!s_retain) begin
            st_nxt.bat_flag = 1'b1;
            st_nxt.wipe     = 1'b1;
            st_nxt.evt      = 1'b1;
            st_nxt.evt_code = sa_pkg::EVT_AUTO_RESET;
            st_nxt.st       = sa_pkg::SA_WIPE;
          end else begin
            st_nxt.st = sa_pkg::SA_DECIDE;
          end
        end
      end
      sa_pkg::SA_WIPE: begin
        st_nxt.wipe = 1'b0;
        if (s_card) begin
          st_nxt.src = 2'(sa_pkg::SA_SRC_CARD);
          st_nxt.st  = sa_pkg::SA_LOAD;
        end else if (s_prot) begin
          st_nxt.src = 2'(sa_pkg::SA_SRC_PROT);
          st_nxt.st  = sa_pkg::SA_LOAD;
        end else begin
          st_nxt.st = sa_pkg::SA_DECIDE;
        end
      end
      sa_pkg::SA_LOAD: begin
        if (s_load_done) begin
          st_nxt.src = 2'(sa_pkg::SA_SRC_NONE);
          st_nxt.st  = sa_pkg::SA_DECIDE;
        end
      end
      sa_pkg::SA_DECIDE: begin
        // Scan all 64 slots; after the last one the lever, battery flag and fault handler decide the mode.
        st_nxt.svalid = calc_valid;
        st_nxt.saddr  = calc_addr;
        if (scan_kind != sa_pkg::KIND_EMPTY && st_r.slot >= 6'(sa_pkg::FIRST_AUTO_SLOT)) begin
          st_nxt.nmod = st_r.nmod + 6'h1;
          st_nxt.nrow = st_r.nrow + 4'h1;
          if (st_r.nmod >= 6'(sa_pkg::MAX_MODULES) || st_r.nrow >= 4'(sa_pkg::MAX_PER_ROW)) begin
            st_nxt.cnt_err = 1'b1;
          end
        end
        if (st_r.slot[2:0] == 3'h7) begin
          st_nxt.nrow = 4'h0;
        end
        st_nxt.slot = st_r.slot + 6'h1;
        if (st_r.slot == 6'h3f) begin
          if (s_lever && (!st_r.bat_flag || s_handler)) begin
            st_nxt.run  = 1'b1;
            st_nxt.exec = s_prog;
            st_nxt.st   = sa_pkg::SA_RUN;
          end else begin
            st_nxt.st = sa_pkg::SA_STOP;
          end
        end
      end
      sa_pkg::SA_STOP: begin
        st_nxt.run  = 1'b0;
        st_nxt.exec = 1'b0;
        if (s_lever && !st_r.lever_q && (!st_r.bat_flag || s_handler)) begin
          st_nxt.run  = 1'b1;
          st_nxt.exec = s_prog;
          st_nxt.st   = sa_pkg::SA_RUN;
        end
      end
      sa_pkg::SA_RUN: begin
        if (!s_lever) begin
          st_nxt.st = sa_pkg::SA_STOP;
        end else if (s_cycle_end) begin
          st_nxt.img_idx = 7'h00;
          st_nxt.st      = sa_pkg::SA_WRITE;
        end else if (bus_wr) begin
          st_nxt.maddr  = bus_addr;
          st_nxt.mwdata = bus_wdata;
          st_nxt.mwr    = !(bus_via_image && img_hit);
        end else if (bus_rd) begin
          st_nxt.maddr = bus_addr;
          st_nxt.mrd   = !(bus_via_image && img_hit);
          st_nxt.rdata = (bus_via_image && img_hit) ? in_image[bus_addr[6:0]] : st_r.rdata;
        end
      end
      sa_pkg::SA_WRITE: begin
        // Flush the output image first so inputs reflect the new outputs.
        st_nxt.mwr     = 1'b1;
        st_nxt.maddr   = 16'(st_r.img_idx);
        st_nxt.mwdata  = out_image[st_r.img_idx];
        st_nxt.img_idx = st_r.img_idx + 7'h1;
        if (st_r.img_idx == sa_pkg::IMAGE_LAST[6:0]) begin
          st_nxt.st = sa_pkg::SA_READ;
        end
      end
      sa_pkg::SA_READ: begin
        st_nxt.mrd     = 1'b1;
        st_nxt.maddr   = 16'(st_r.img_idx);
        st_nxt.img_idx = st_r.img_idx + 7'h1;
        if (st_r.img_idx == sa_pkg::IMAGE_LAST[6:0]) begin
          st_nxt.st = sa_pkg::SA_IDLE;
        end
      end
      sa_pkg::SA_IDLE: begin
        st_nxt.st = sa_pkg::SA_RUN;
      end
      default: begin
        st_nxt.st = sa_pkg::SA_CHECK;
      end
    endcase
    // Direct read data returns when the module answers.
    if (st_r.mrd && st_r.st == sa_pkg::SA_RUN) begin
      st_nxt.rdata = mod_rdata;
    end
  end

  // State register; reset puts every field at a constant.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r    <= '0;
      st_r.st <= sa_pkg::SA_CHECK;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Image memories; the input image samples one cycle behind each refresh read strobe, not behind direct reads.
  always_ff @(posedge ref_clk) begin
    if (st_r.st == sa_pkg::SA_RUN && bus_wr && bus_via_image && img_hit && s_lever && !s_cycle_end) begin
      out_image[bus_addr[6:0]] <= bus_wdata;
    end
    if (st_r.mrd && st_r.st != sa_pkg::SA_RUN && st_r.maddr <= 16'(sa_pkg::IMAGE_LAST)) begin
      in_image[st_r.maddr[6:0]] <= mod_rdata;
    end
  end

  assign scan_slot          = st_r.slot;
  assign slot_addr          = st_r.saddr;
  assign slot_addr_valid    = st_r.svalid;
  assign slot_count_error   = st_r.cnt_err;
  assign run_mode           = st_r.run;
  assign program_exec       = st_r.exec;
  assign overall_reset      = st_r.wipe;
  assign load_source        = st_r.src;
  assign battery_fault_flag = st_r.bat_flag;
  // Charging runs whenever powered; retention length is the battery's, not ours.
  assign battery_charge_en  = 1'b1;
  assign diag_event_valid   = st_r.evt;
  assign diag_event_code    = st_r.evt_code;
  assign mod_wr             = st_r.mwr;
  assign mod_rd             = st_r.mrd;
  assign mod_addr           = st_r.maddr;
  assign mod_wdata          = st_r.mwdata;
  assign bus_rdata          = st_r.rdata;
endmodule : sa_startup
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the start-up sequencer and slot allocator.
// Assumes the backplane model answers scans and module reads at once.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned CLR = 200;
  logic ref_clk = 1'b0, rst = 1'b1, dense = 1'b0, cycle_end = 1'b0;
  logic lever_run, retained_valid, program_present, battery_full;
  logic card_present, protected_present, fault_handler_present, hw_config_valid;
  logic bus_wr = 1'b0, bus_rd = 1'b0, bus_via_image = 1'b0;
  logic [15:0] bus_addr = 16'h0000, slot_addr, mod_addr, scan_cfg_addr, exp_a;
  logic [7:0] bus_wdata = 8'h00, mod_rdata, mod_wdata, bus_rdata, diag_event_code, diag_seen;
  logic [5:0] scan_slot, prev_slot;
  logic [1:0] scan_kind, prev_kind, load_source, src_seen;
  logic slot_addr_valid, slot_count_error, run_mode, program_exec, overall_reset;
  logic battery_fault_flag, battery_charge_en, diag_event_valid, mod_wr, mod_rd;
  int n_mismatch = 0, n_checks = 0, n_wipe, n_addr, nw, nr, i;
  always #50 ref_clk = ~ref_clk;
  sa_startup #(.BAT_CLEAR_CYCLES(CLR)) sa_startup_inst (.ref_clk, .rst, .lever_run, .retained_valid,
    .program_present, .battery_full, .card_present, .protected_present, .fault_handler_present,
    .hw_config_valid, .load_done(1'b1), .cycle_end, .scan_kind, .scan_cfg_addr, .bus_wr, .bus_rd,
    .bus_via_image, .bus_addr, .bus_wdata, .mod_rdata, .scan_slot, .slot_addr, .slot_addr_valid,
    .slot_count_error, .run_mode, .program_exec, .overall_reset, .load_source, .battery_fault_flag,
    .battery_charge_en, .diag_event_valid, .diag_event_code, .mod_wr, .mod_rd, .mod_addr, .mod_wdata,
    .bus_rdata);
  sa_backplane sa_backplane_inst (.dense, .scan_slot, .mod_addr, .scan_kind, .scan_cfg_addr, .mod_rdata);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  // Sampled on the falling edge, so registered outputs have settled.
  always @(negedge ref_clk) begin
    if (overall_reset === 1'b1) n_wipe++;
    if (diag_event_valid === 1'b1) diag_seen = diag_event_code;
    if (load_source !== 2'h0) src_seen = load_source;
    if (slot_addr_valid === 1'b1) begin
      n_addr++;
      exp_a = ({10'h000, prev_slot} - 16'h0004) << ((prev_kind == sa_pkg::KIND_DIGITAL) ? 2 : 4);
      if (prev_kind != sa_pkg::KIND_DIGITAL) exp_a = exp_a + sa_pkg::ANA_BASE;
      if (hw_config_valid) exp_a = {10'h028, prev_slot};
      check(slot_addr, exp_a);
    end
    prev_slot = scan_slot;
    prev_kind = scan_kind;
  end
  // Bits: lever, retained, program, battery full, card, protected, handler, config.
  task automatic power_up(input logic [7:0] v);
    {lever_run, retained_valid, program_present, battery_full} = v[7:4];
    {card_present, protected_present, fault_handler_present, hw_config_valid} = v[3:0];
    rst = 1'b1;
    n_wipe = 0;
    n_addr = 0;
    src_seen = 2'h0;
    diag_seen = 8'h00;
    step(8);
    rst = 1'b0;
  endtask : power_up
  task automatic wait_run(input logic e);
    for (i = 0; i < 300 && run_mode !== 1'b1; i++) step(1);
    check(run_mode, e);
    if (e && run_mode !== 1'b1) give_verdict();
  endtask : wait_run
  // The request stays up until the caller issues the next one or idles.
  task automatic bus_op(input logic wr, input logic img, input logic [15:0] a, input logic [7:0] d);
    {bus_wr, bus_rd, bus_via_image, bus_addr, bus_wdata} = {wr, !wr, img, a, d};
    step(1);
  endtask : bus_op
  initial begin
    power_up(8'h9a);
    wait_run(1'b1);
    check(n_wipe, 1);
    check(src_seen, sa_pkg::SA_SRC_CARD);
    check(diag_seen, sa_pkg::EVT_AUTO_RESET);
    check(battery_fault_flag, 1'b1);
    check(n_addr, 3);
    $display("done empty battery with card");
    power_up(8'h95);
    wait_run(1'b0);
    check(src_seen, sa_pkg::SA_SRC_PROT);
    $display("done empty battery without card");
    power_up(8'h9a);
    step(20);
    check(battery_fault_flag, 1'b1);
    power_up(8'h9a);
    step(150);
    check({n_wipe[7:0], battery_fault_flag}, 9'h003);
    step(CLR);
    check(battery_fault_flag, 1'b0);
    $display("done battery flag timing");
    power_up(8'h50);
    wait_run(1'b0);
    lever_run = 1'b1;
    wait_run(1'b1);
    check(program_exec, 1'b0);
    $display("done factory state");
    dense = 1'b1;
    power_up(8'hf0);
    step(150);
    check(slot_count_error, 1'b1);
    dense = 1'b0;
    $display("done full rack");
    power_up(8'hf0);
    wait_run(1'b1);
    check({program_exec, slot_count_error, n_wipe[7:0]}, 10'h200);
    bus_op(1'b1, 1'b0, 16'h0204, 8'hc3);
    check({mod_wr, mod_addr, mod_wdata}, {1'b1, 16'h0204, 8'hc3});
    bus_op(1'b0, 1'b0, 16'h0204, 8'h00);
    check({mod_rd, mod_addr}, {1'b1, 16'h0204});
    {bus_wr, bus_rd} = 2'b00;
    step(1);
    check(bus_rdata, 8'hf9);
    bus_op(1'b1, 1'b1, 16'h0010, 8'h5a);
    check(mod_wr, 1'b0);
    {bus_wr, bus_rd} = 2'b00;
    cycle_end = 1'b1;
    step(1);
    cycle_end = 1'b0;
    nw = 0;
    nr = 0;
    for (i = 0; i < 600 && nr < 128; i++) begin
      step(1);
      if (mod_wr === 1'b1) begin
        check(mod_addr, nw);
        if (nw == 16) check(mod_wdata, 8'h5a);
        nw++;
      end
      if (mod_rd === 1'b1) begin
        check({mod_addr, nw[15:0]}, {nr[15:0], 16'd128});
        nr++;
      end
    end
    if (nr < 128) begin
      n_mismatch++;
      give_verdict();
    end
    // The sequencer spends one idle cycle after the refresh, and ignores requests there.
    step(1);
    bus_op(1'b0, 1'b1, 16'h0010, 8'h00);
    check(bus_rdata, 8'hef);
    {bus_wr, bus_rd} = 2'b00;
    $display("done bus and image refresh");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
